//--- hdl/expansion_bus_top.sv
// expansion bus interface of the single-board computer
`timescale 1ns/1ps
`default_nettype none
// Function
// - write data held across strobe trailing edge
// - address valid from latch-enable fall to end
// - latch pulse marks low address and status
// - address enable high only in dma cycles
// - cycle type shows memory or io space
// - bus clock is half the crystal rate
// - ready low inserts wait states
// - reset clears pc, interrupt enable, hold ack
// - reset output high while processor in reset
// - irq acknowledge replaces memory read on fetch
// - trap jumps to 0024h
// - low vectored interrupt restarts at 002Ch
// - onboard select for lowest 3K of memory
// - high vectored interrupt calls 003Ch
module expansion_bus_top
    import exp_bus_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CRYSTAL_CLK,
    input  wire logic        RESET_IN_N,
    input  wire logic        CPU_REQ,
    input  wire logic [2:0]  CPU_KIND,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic [7:0]  CPU_WDATA,
    output logic             CPU_BUSY,
    output logic             CPU_DONE,
    output logic [7:0]       CPU_RDATA,
    input  wire logic        CPU_EI,
    input  wire logic        CPU_DI,
    input  wire logic        CPU_HOLD,
    input  wire logic        CPU_PC_LOAD,
    input  wire logic [15:0] CPU_PC_VALUE,
    output logic [15:0]      PROGRAM_COUNTER,
    output logic             INTERRUPT_ENABLE_FLAG,
    output logic             HOLD_ACKNOWLEDGE_FLAG,
    output logic             IRQ_TAKEN,
    output logic [7:0]       IRQ_OPCODE,
    input  wire logic        DMA_ACTIVE,
    output logic [15:0]      BUS_ADDRESS_LINES,
    input  wire logic [7:0]  BUS_DATA_LINES_IN,
    output logic [7:0]       BUS_DATA_LINES_OUT,
    output logic             BUS_DATA_LINES_OE,
    output logic             ADDR_LATCH_ENABLE,
    output logic             CYCLE_STATUS_BIT0,
    output logic             CYCLE_STATUS_BIT1,
    output logic             IO_NOT_MEM,
    output logic             MEM_READ_STROBE_N,
    output logic             MEM_WRITE_STROBE_N,
    output logic             IO_READ_STROBE_N,
    output logic             IO_WRITE_STROBE_N,
    output logic             IRQ_ACKNOWLEDGE_N,
    output logic             DMA_ADDRESS_ENABLE,
    output logic             ONBOARD_MEM_SELECT,
    output logic             BUS_CLOCK,
    input  wire logic        READY,
    output logic             RESET_OUT,
    input  wire logic        GENERAL_IRQ_REQUEST,
    input  wire logic        TRAP_REQUEST,
    input  wire logic        VECTORED_IRQ_LOW,
    input  wire logic        VECTORED_IRQ_HIGH,
    input  wire logic [1:0]  VECTORED_IRQ_MASK
);
    cycle_req_if req ();

    logic       rst_in_meta;
    logic       rst_in_s;
    logic       cpu_reset;
    logic       bus_rst_meta;
    logic       bus_rst;
    logic       done_meta;
    logic       done_s;
    logic       done_seen;
    logic       busy;
    logic [2:0] irq_meta;
    logic [2:0] irq_s;
    logic [2:0] irq_prev;
    logic       gen_meta;
    logic       gen_s;
    logic       ack_pending;
    logic       high_latch;
    logic       dma_meta;
    logic       dma_s;
    logic [1:0] status_bits;
    logic       clk_div = 1'b0;

    // reset pin is asynchronous to the system clock
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rst_in_meta <= 1'b0;
            rst_in_s    <= 1'b0;
        end else begin
            rst_in_meta <= RESET_IN_N;
            rst_in_s    <= rst_in_meta;
        end
    end

    assign cpu_reset = SYS_RST || !rst_in_s;
    assign RESET_OUT = cpu_reset;

    // bus clock is made from the crystal, so its half rate is exact
    always_ff @(posedge CRYSTAL_CLK) begin
        clk_div <= ~clk_div;
    end
    assign BUS_CLOCK = clk_div;

    // bus domain reset and dma level crossed into the bus domain
    always_ff @(posedge CRYSTAL_CLK) begin
        bus_rst_meta <= cpu_reset;
        bus_rst      <= bus_rst_meta;
        dma_meta     <= DMA_ACTIVE;
        dma_s        <= dma_meta;
    end

    // request handshake: toggle out, toggle back
    always_ff @(posedge SYS_CLK) begin
        if (cpu_reset) begin
            req.req_toggle <= 1'b0;
            req.kind       <= KIND_MEM_READ;
            req.addr       <= RESET_PC;
            req.wdata      <= 8'h00;
            busy           <= 1'b0;
            done_meta      <= 1'b0;
            done_s         <= 1'b0;
            done_seen      <= 1'b0;
            CPU_DONE       <= 1'b0;
            CPU_RDATA      <= 8'h00;
            ack_pending    <= 1'b0;
        end else begin
            done_meta <= req.done_toggle;
            done_s    <= done_meta;
            done_seen <= done_s;
            CPU_DONE  <= 1'b0;
            if (busy && done_s != done_seen) begin
                busy      <= 1'b0;
                CPU_DONE  <= 1'b1;
                CPU_RDATA <= req.rdata;
            end else if (!busy && CPU_REQ && !HOLD_ACKNOWLEDGE_FLAG) begin
                // fetch after an accepted general request becomes an acknowledge
                if (ack_pending && CPU_KIND == KIND_MEM_READ) begin
                    req.kind    <= KIND_IRQ_ACK;
                    ack_pending <= 1'b0;
                end else begin
                    req.kind <= CPU_KIND;
                end
                req.addr       <= CPU_ADDR;
                req.wdata      <= CPU_WDATA;
                req.req_toggle <= ~req.req_toggle;
                busy           <= 1'b1;
            end
            if (IRQ_TAKEN && irq_pick() == 2'd0) begin
                ack_pending <= 1'b1;
            end
        end
    end
    assign CPU_BUSY = busy;

    // interrupt inputs are pins: two flops before use
    always_ff @(posedge SYS_CLK) begin
        if (cpu_reset) begin
            irq_meta <= 3'h0;
            irq_s    <= 3'h0;
            irq_prev <= 3'h0;
            gen_meta <= 1'b0;
            gen_s    <= 1'b0;
        end else begin
            irq_meta <= {TRAP_REQUEST, VECTORED_IRQ_HIGH, VECTORED_IRQ_LOW};
            irq_s    <= irq_meta;
            irq_prev <= irq_s;
            gen_meta <= GENERAL_IRQ_REQUEST;
            gen_s    <= gen_meta;
        end
    end

    // high vectored input is edge latched, the edge survives a busy cycle
    always_ff @(posedge SYS_CLK) begin
        if (cpu_reset) begin
            high_latch <= 1'b0;
        end else if (irq_s[1] && !irq_prev[1]) begin
            high_latch <= 1'b1;
        end else if (IRQ_TAKEN && irq_pick() == 2'd2) begin
            high_latch <= 1'b0;
        end
    end

    // priority: trap, high vectored, low vectored, general request
    function automatic logic [1:0] irq_pick();
        if (irq_s[2] && !irq_prev[2]) begin
            return 2'd3;
        end
        if (high_latch && INTERRUPT_ENABLE_FLAG && !VECTORED_IRQ_MASK[1]) begin
            return 2'd2;
        end
        if (irq_s[0] && INTERRUPT_ENABLE_FLAG && !VECTORED_IRQ_MASK[0]) begin
            return 2'd1;
        end
        return 2'd0;
    endfunction

    always_comb begin
        IRQ_TAKEN = 1'b0;
        if (!busy && !cpu_reset) begin
            IRQ_TAKEN = (irq_pick() != 2'd0) ||
                        (gen_s && INTERRUPT_ENABLE_FLAG && !ack_pending);
        end
    end

    // program counter, interrupt enable and hold acknowledge
    always_ff @(posedge SYS_CLK) begin
        if (cpu_reset) begin
            PROGRAM_COUNTER       <= RESET_PC;
            INTERRUPT_ENABLE_FLAG <= 1'b0;
            HOLD_ACKNOWLEDGE_FLAG <= 1'b0;
            IRQ_OPCODE            <= 8'h00;
        end else begin
            HOLD_ACKNOWLEDGE_FLAG <= CPU_HOLD && !busy;
            if (IRQ_TAKEN) begin
                INTERRUPT_ENABLE_FLAG <= 1'b0;
                case (irq_pick())
                    2'd3:    PROGRAM_COUNTER <= TRAP_VECTOR;
                    2'd2:    PROGRAM_COUNTER <= VEC_HIGH_VECTOR;
                    2'd1:    PROGRAM_COUNTER <= VEC_LOW_VECTOR;
                    default: IRQ_OPCODE <= RESTART_OPCODE;
                endcase
            end else if (CPU_PC_LOAD) begin
                PROGRAM_COUNTER <= CPU_PC_VALUE;
            end
            if (!IRQ_TAKEN && CPU_EI) begin
                INTERRUPT_ENABLE_FLAG <= 1'b1;
            end else if (!IRQ_TAKEN && CPU_DI) begin
                INTERRUPT_ENABLE_FLAG <= 1'b0;
            end
        end
    end

    bus_cycle_engine engine (
        .bus_clk          (clk_div),
        .bus_rst          (bus_rst),
        .req              (req),
        .ready_in         (READY),
        .dma_active       (dma_s),
        .addr_out         (BUS_ADDRESS_LINES),
        .data_out         (BUS_DATA_LINES_OUT),
        .data_oe          (BUS_DATA_LINES_OE),
        .data_in          (BUS_DATA_LINES_IN),
        .ale              (ADDR_LATCH_ENABLE),
        .status           (status_bits),
        .io_not_mem       (IO_NOT_MEM),
        .strobes_n_mem_rd (MEM_READ_STROBE_N),
        .strobes_n_mem_wr (MEM_WRITE_STROBE_N),
        .strobes_n_io_rd  (IO_READ_STROBE_N),
        .strobes_n_io_wr  (IO_WRITE_STROBE_N),
        .strobes_n_ack    (IRQ_ACKNOWLEDGE_N),
        .addr_en          (DMA_ADDRESS_ENABLE)
    );

    assign CYCLE_STATUS_BIT0 = status_bits[0];
    assign CYCLE_STATUS_BIT1 = status_bits[1];
    // decoded from the held address, so it tracks the whole cycle
    assign ONBOARD_MEM_SELECT = !IO_NOT_MEM &&
                                in_onboard_mem(BUS_ADDRESS_LINES);
endmodule
`default_nettype wire

//--- hdl/exp_bus_pkg.sv
// constants and types shared by the expansion bus interface
package exp_bus_pkg;
    localparam logic [15:0] TRAP_VECTOR      = 16'h0024;
    localparam logic [15:0] VEC_LOW_VECTOR   = 16'h002C;
    localparam logic [15:0] VEC_HIGH_VECTOR  = 16'h003C;
    localparam logic [15:0] ONBOARD_MEM_SIZE = 16'h0C00;
    localparam logic [15:0] RESET_PC         = 16'h0000;
    localparam logic [7:0]  RESTART_OPCODE   = 8'hFF;
    localparam logic [1:0]  STATUS_HALT      = 2'h0;
    localparam logic [1:0]  STATUS_WRITE     = 2'h1;
    localparam logic [1:0]  STATUS_READ      = 2'h2;
    localparam logic [1:0]  STATUS_FETCH     = 2'h3;

    typedef enum logic [5:0] {
        CYC_IDLE  = 6'b00_0001,
        CYC_ALE   = 6'b00_0010,
        CYC_STRB  = 6'b00_0100,
        CYC_WAIT  = 6'b00_1000,
        CYC_END   = 6'b01_0000,
        CYC_DONE  = 6'b10_0000
    } cycle_state_e;

    typedef enum logic [2:0] {
        KIND_MEM_READ  = 3'h0,
        KIND_MEM_WRITE = 3'h1,
        KIND_IO_READ   = 3'h2,
        KIND_IO_WRITE  = 3'h3,
        KIND_IRQ_ACK   = 3'h4
    } cycle_kind_e;

    function automatic logic in_onboard_mem(input logic [15:0] addr);
        return addr < ONBOARD_MEM_SIZE;
    endfunction
endpackage

//--- hdl/cycle_req_if.sv
// request and answer path between system side and bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface cycle_req_if;
    logic        req_toggle;
    logic [2:0]  kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        done_toggle;
    logic [7:0]  rdata;
    modport sys (output req_toggle, kind, addr, wdata,
                 input done_toggle, rdata);
    modport link (input req_toggle, kind, addr, wdata,
                  output done_toggle, rdata);
endinterface
`default_nettype wire

//--- hdl/bus_cycle_engine.sv
// bus cycle engine in the bus clock domain
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_engine
    import exp_bus_pkg::*;
(
    input  wire logic   bus_clk,
    input  wire logic   bus_rst,
    cycle_req_if.link   req,
    input  wire logic   ready_in,
    input  wire logic   dma_active,
    output logic [15:0] addr_out,
    output logic [7:0]  data_out,
    output logic        data_oe,
    input  wire logic [7:0] data_in,
    output logic        ale,
    output logic [1:0]  status,
    output logic        io_not_mem,
    output logic        strobes_n_mem_rd,
    output logic        strobes_n_mem_wr,
    output logic        strobes_n_io_rd,
    output logic        strobes_n_io_wr,
    output logic        strobes_n_ack,
    output logic        addr_en
);
    cycle_state_e state;
    logic [2:0]  req_sync;
    logic        ready_meta;
    logic        ready_s;
    cycle_kind_e kind;
    logic        active_strobe;

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            req_sync   <= 3'h0;
            ready_meta <= 1'b1;
            ready_s    <= 1'b1;
        end else begin
            req_sync   <= {req_sync[1:0], req.req_toggle};
            ready_meta <= ready_in;
            ready_s    <= ready_meta;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            state           <= CYC_IDLE;
            kind            <= KIND_MEM_READ;
            addr_out        <= 16'h0000;
            data_out        <= 8'h00;
            data_oe         <= 1'b0;
            ale             <= 1'b0;
            status          <= STATUS_HALT;
            io_not_mem      <= 1'b0;
            active_strobe   <= 1'b0;
            req.done_toggle <= 1'b0;
            req.rdata       <= 8'h00;
        end else begin
            case (state)
                CYC_IDLE: begin
                    if (req_sync[2] != req_sync[1]) begin
                        kind       <= cycle_kind_e'(req.kind);
                        addr_out   <= req.addr;
                        data_out   <= req.wdata;
                        ale        <= 1'b1;
                        io_not_mem <= (req.kind == KIND_IO_READ) ||
                                      (req.kind == KIND_IO_WRITE);
                        case (cycle_kind_e'(req.kind))
                            KIND_MEM_WRITE, KIND_IO_WRITE:
                                status <= STATUS_WRITE;
                            KIND_IRQ_ACK:   status <= STATUS_FETCH;
                            default:        status <= STATUS_READ;
                        endcase
                        state <= CYC_ALE;
                    end
                end
                CYC_ALE: begin
                    ale           <= 1'b0;
                    data_oe       <= (kind == KIND_MEM_WRITE) ||
                                     (kind == KIND_IO_WRITE);
                    active_strobe <= 1'b1;
                    state         <= CYC_STRB;
                end
                CYC_STRB: begin
                    if (ready_s) begin
                        state <= CYC_END;
                    end else begin
                        state <= CYC_WAIT;
                    end
                end
                CYC_WAIT: begin
                    if (ready_s) begin
                        state <= CYC_END;
                    end
                end
                CYC_END: begin
                    // data sampled at the strobe's rising edge
                    req.rdata     <= data_in;
                    active_strobe <= 1'b0;
                    state         <= CYC_DONE;
                end
                CYC_DONE: begin
                    // write data held one clock past the trailing edge
                    data_oe         <= 1'b0;
                    status          <= STATUS_HALT;
                    req.done_toggle <= ~req.done_toggle;
                    state           <= CYC_IDLE;
                end
                default: state <= CYC_IDLE;
            endcase
        end
    end

    // a single decoded kind keeps the strobes mutually exclusive
    assign strobes_n_mem_rd = ~(active_strobe &&
                               kind == KIND_MEM_READ);
    assign strobes_n_mem_wr = ~(active_strobe && kind == KIND_MEM_WRITE);
    assign strobes_n_io_rd  = ~(active_strobe && kind == KIND_IO_READ);
    assign strobes_n_io_wr  = ~(active_strobe && kind == KIND_IO_WRITE);
    assign strobes_n_ack    = ~(active_strobe &&
                               kind == KIND_IRQ_ACK);
    assign addr_en          = dma_active && !bus_rst;
endmodule
`default_nettype wire

//--- verification/exp_bus_properties.sv
// concurrent checks on the expansion bus interface top ports
`timescale 1ns/1ps
`default_nettype none
module exp_bus_properties
    import exp_bus_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        CRYSTAL_CLK,
    input wire logic        RESET_OUT,
    input wire logic [15:0] PROGRAM_COUNTER,
    input wire logic        INTERRUPT_ENABLE_FLAG,
    input wire logic        HOLD_ACKNOWLEDGE_FLAG,
    input wire logic        DMA_ACTIVE,
    input wire logic        DMA_ADDRESS_ENABLE,
    input wire logic        ADDR_LATCH_ENABLE,
    input wire logic [15:0] BUS_ADDRESS_LINES,
    input wire logic        CYCLE_STATUS_BIT0,
    input wire logic        CYCLE_STATUS_BIT1,
    input wire logic        IO_NOT_MEM,
    input wire logic [7:0]  BUS_DATA_LINES_OUT,
    input wire logic        BUS_DATA_LINES_OE,
    input wire logic        MEM_READ_STROBE_N,
    input wire logic        MEM_WRITE_STROBE_N,
    input wire logic        IO_READ_STROBE_N,
    input wire logic        IO_WRITE_STROBE_N,
    input wire logic        IRQ_ACKNOWLEDGE_N,
    input wire logic        ONBOARD_MEM_SELECT
);
    wire logic [4:0]  strb_n = {MEM_READ_STROBE_N, MEM_WRITE_STROBE_N,
                                IO_READ_STROBE_N, IO_WRITE_STROBE_N,
                                IRQ_ACKNOWLEDGE_N};
    wire logic        busy = !(&strb_n);
    wire logic [18:0] info = {BUS_ADDRESS_LINES, CYCLE_STATUS_BIT1,
                              CYCLE_STATUS_BIT0, IO_NOT_MEM};
    // bus side sampled on the crystal clock: two samples per bus clock
    property p_one_strobe;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT) $onehot0(~strb_n);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("two strobes low at once");
    property p_ale_pulse;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        $rose(ADDR_LATCH_ENABLE) |-> ##1 (ADDR_LATCH_ENABLE
            && $stable(info)) ##1 !ADDR_LATCH_ENABLE;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("latch pulse width or status wrong");
    property p_addr_hold;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        $fell(ADDR_LATCH_ENABLE) || (busy && $past(busy)) |-> $stable(info);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved inside the cycle");
    property p_wr_data;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        $rose(MEM_WRITE_STROBE_N) || $rose(IO_WRITE_STROBE_N)
            |-> BUS_DATA_LINES_OE && $stable(BUS_DATA_LINES_OUT);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write data not held over strobe end");
    property p_io_type;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        busy |-> IO_NOT_MEM == !(IO_READ_STROBE_N && IO_WRITE_STROBE_N);
    endproperty
    a_io_type: assert property (p_io_type)
        else $error("cycle type disagrees with strobe");
    property p_msel;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        !(MEM_READ_STROBE_N && MEM_WRITE_STROBE_N) |->
            ONBOARD_MEM_SELECT == (BUS_ADDRESS_LINES < ONBOARD_MEM_SIZE);
    endproperty
    a_msel: assert property (p_msel)
        else $error("onboard select wrong for address");
    property p_aen;
        @(posedge CRYSTAL_CLK) disable iff (RESET_OUT)
        !DMA_ACTIVE [*8] |=> !DMA_ADDRESS_ENABLE;
    endproperty
    a_aen: assert property (p_aen)
        else $error("address enable high outside dma");
    // not disabled by reset: reset itself is what is checked
    property p_reset_state;
        @(posedge SYS_CLK) RESET_OUT && $past(RESET_OUT) |->
            PROGRAM_COUNTER == RESET_PC && !INTERRUPT_ENABLE_FLAG
            && !HOLD_ACKNOWLEDGE_FLAG;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("processor state not cleared in reset");
endmodule
bind expansion_bus_top exp_bus_properties u_props (.*);
`default_nettype wire

//--- verification/exp_card_model.sv
// expansion card model: byte memory and io registers behind strobes
`timescale 1ns/1ps
`default_nettype none
module exp_card_model
    import exp_bus_pkg::*;
#(
    parameter int WAIT_CLKS = 4
) (
    input  wire logic        bus_clk,
    input  wire logic        slow,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [4:0]  strb_n,
    output logic [7:0]       rdata,
    output logic             ready
);
    // strb_n order: mem read, mem write, io read, io write, acknowledge
    logic [7:0] mem [256];
    logic [7:0] io [256];
    logic [7:0] last = 8'h00;
    int         cnt = 0;
    wire logic  drive = !(strb_n[4] && strb_n[2] && strb_n[0]);
    always @(posedge strb_n[3]) mem[addr[7:0]] <= wdata;
    always @(posedge strb_n[1]) io[addr[7:0]] <= wdata;
    always_comb begin
        if (!strb_n[4]) begin
            rdata = mem[addr[7:0]];
        end else if (!strb_n[2]) begin
            rdata = io[addr[7:0]];
        end else if (!strb_n[0]) begin
            rdata = RESTART_OPCODE;
        end else begin
            rdata = ~last; // released bus must not look like held data
        end
    end
    always @(posedge bus_clk) begin
        if (drive) last <= rdata;
        cnt <= (&strb_n) ? 0 : cnt + 1;
    end
    // push-pull: the model drives ready both high and low itself
    // ready passes two bus flops, so a slow card holds it low ahead
    assign ready = !(slow && cnt < WAIT_CLKS);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the expansion bus interface
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin comparisons++; \
    if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import exp_bus_pkg::*;
;
    logic        sys_clk, sys_rst, xtal, reset_in_n, req, ei, hold, pc_load;
    logic        dma, gen, trap, vlow, vhigh, slow, ready;
    logic        busy, done, ie, hold_acknowledge_flag, taken, doe, io_m, dma_address_enable, msel, bclk;
    logic        rst_out, m_io, m_sel, m_ack;
    logic [1:0]  mask;
    logic [2:0]  kind;
    logic [15:0] addr, pc_value, pc, baddr, m_addr;
    logic [7:0]  wdata, rdata, opcode, dout, card_q;
    wire  [4:0]  strb_n;
    wire  [7:0]  dbus = doe ? dout : card_q;
    wire         all_high = &strb_n;
    int          fails = 0, comparisons = 0, len_run = 0, m_len, bcnt = 0;

    expansion_bus_top dut (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CRYSTAL_CLK(xtal),
        .RESET_IN_N(reset_in_n), .CPU_REQ(req), .CPU_KIND(kind),
        .CPU_ADDR(addr), .CPU_WDATA(wdata), .CPU_BUSY(busy),
        .CPU_DONE(done), .CPU_RDATA(rdata), .CPU_EI(ei), .CPU_DI(1'b0),
        .CPU_HOLD(hold), .CPU_PC_LOAD(pc_load), .CPU_PC_VALUE(pc_value),
        .PROGRAM_COUNTER(pc), .INTERRUPT_ENABLE_FLAG(ie),
        .HOLD_ACKNOWLEDGE_FLAG(hold_acknowledge_flag), .IRQ_TAKEN(taken),
        .IRQ_OPCODE(opcode), .DMA_ACTIVE(dma), .BUS_ADDRESS_LINES(baddr),
        .BUS_DATA_LINES_IN(dbus), .BUS_DATA_LINES_OUT(dout),
        .BUS_DATA_LINES_OE(doe), .ADDR_LATCH_ENABLE(),
        .CYCLE_STATUS_BIT0(), .CYCLE_STATUS_BIT1(), .IO_NOT_MEM(io_m),
        .MEM_READ_STROBE_N(strb_n[4]), .MEM_WRITE_STROBE_N(strb_n[3]),
        .IO_READ_STROBE_N(strb_n[2]), .IO_WRITE_STROBE_N(strb_n[1]),
        .IRQ_ACKNOWLEDGE_N(strb_n[0]), .DMA_ADDRESS_ENABLE(dma_address_enable),
        .ONBOARD_MEM_SELECT(msel), .BUS_CLOCK(bclk), .READY(ready),
        .RESET_OUT(rst_out), .GENERAL_IRQ_REQUEST(gen),
        .TRAP_REQUEST(trap), .VECTORED_IRQ_LOW(vlow),
        .VECTORED_IRQ_HIGH(vhigh), .VECTORED_IRQ_MASK(mask));
    exp_card_model card (.bus_clk(bclk), .slow(slow), .addr(baddr),
        .wdata(dbus), .strb_n(strb_n), .rdata(card_q), .ready(ready));

    initial begin sys_clk = 0; forever #12.5 sys_clk = ~sys_clk; end
    initial begin xtal = 0; #7; forever #32 xtal = ~xtal; end
    // bus-side view at strobe fall, and strobe length in crystal clocks
    always @(negedge all_high) begin
        m_addr = baddr; m_io = io_m; m_sel = msel; m_ack = !strb_n[0];
    end
    always @(posedge xtal) len_run <= all_high ? 0 : len_run + 1;
    always @(posedge all_high) m_len = len_run;
    always @(posedge bclk) bcnt++;

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 2000) begin @(negedge sys_clk); n++; end
        if (s !== 1'b1) begin fails++; results(); end
    endtask
    task automatic cyc(input logic [2:0] k, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge sys_clk); req = 1; kind = k; addr = a; wdata = d;
        @(negedge sys_clk); wait_hi(busy);
        req = 0;
        wait_hi(done);
        q = rdata;
    endtask
    task automatic t_reset();
        `CHECK("pc_boot", RESET_PC, pc)
        @(negedge sys_clk); pc_load = 1; pc_value = 16'h1234; ei = 1;
        hold = 1;
        @(negedge sys_clk); pc_load = 0; ei = 0;
        repeat (3) @(negedge sys_clk);
        `CHECK("ie_set", 1'b1, ie)
        `CHECK("hold_set", 1'b1, hold_acknowledge_flag)
        reset_in_n = 0;
        repeat (6) @(negedge sys_clk);
        `CHECK("rst_out_on", 1'b1, rst_out)
        `CHECK("pc_clr", RESET_PC, pc)
        `CHECK("ie_clr", 1'b0, ie)
        `CHECK("hold_clr", 1'b0, hold_acknowledge_flag)
        reset_in_n = 1; hold = 0;
        repeat (60) @(negedge sys_clk);
        `CHECK("rst_out_off", 1'b0, rst_out)
    endtask
    task automatic t_clk();
        int c0 = bcnt;
        repeat (64) @(negedge xtal);
        `CHECK("bus_clk_edges", 32, bcnt - c0)
    endtask
    task automatic t_rw();
        logic [2:0]  k [6] = '{3'h1, 3'h1, 3'h3, 3'h0, 3'h0, 3'h2};
        logic [15:0] a [6] = '{16'h0BFF, 16'h0C00, 16'h0080,
                               16'h0BFF, 16'h0C00, 16'h0080};
        logic [7:0]  d [6] = '{8'h5A, 8'hC3, 8'h96, 8'h5A, 8'hC3, 8'h96};
        logic [7:0]  q;
        for (int i = 0; i < 6; i++) begin
            cyc(k[i], a[i], d[i], q);
            `CHECK("strobe_addr", a[i], m_addr)
            `CHECK("io_m", k[i][1], m_io)
            if (!k[i][1])
                `CHECK("msel", a[i] < ONBOARD_MEM_SIZE, m_sel)
            if (!k[i][0]) `CHECK("rdata", d[i], q)
        end
    endtask
    task automatic t_slow();
        logic [7:0] q;
        int         fast;
        cyc(3'h2, 16'h0080, 8'h00, q);
        fast = m_len;
        slow = 1;
        cyc(3'h2, 16'h0080, 8'h00, q);
        slow = 0;
        `CHECK("slow_data", 8'h96, q)
        `CHECK("wait_longer", 1'b1, m_len > fast)
    endtask
    task automatic t_dma();
        dma = 1; repeat (20) @(negedge sys_clk);
        `CHECK("aen_on", 1'b1, dma_address_enable)
        dma = 0; repeat (20) @(negedge sys_clk);
        `CHECK("aen_off", 1'b0, dma_address_enable)
    endtask
    // src: 0 general, 1 low vectored, 2 high vectored, 3 trap
    task automatic irq(input int src, input logic [15:0] vec);
        @(negedge sys_clk); ei = 1;
        @(negedge sys_clk); ei = 0;
        {trap, vhigh, vlow, gen} = 4'h1 << src;
        wait_hi(taken);
        {trap, vhigh, vlow, gen} = 4'h0;
        repeat (2) @(negedge sys_clk);
        if (src > 0) `CHECK("vector", vec, pc)
    endtask
    task automatic t_mask_ack();
        logic       seen = 0;
        logic [7:0] q;
        @(negedge sys_clk); ei = 1; mask = 2'b01;
        @(negedge sys_clk); ei = 0; vlow = 1;
        repeat (30) begin @(negedge sys_clk); seen |= taken; end
        `CHECK("masked", 1'b0, seen)
        vlow = 0;
        irq(0, RESET_PC);
        `CHECK("opcode", RESTART_OPCODE, opcode)
        cyc(3'h0, 16'h0BFF, 8'h00, q);
        `CHECK("ack_used", 1'b1, m_ack)
        cyc(3'h0, 16'h0BFF, 8'h00, q);
        `CHECK("ack_once", 1'b0, m_ack)
    endtask

    initial begin
        sys_rst = 1; reset_in_n = 1; req = 0; ei = 0; hold = 0;
        pc_load = 0; dma = 0; gen = 0; trap = 0; vlow = 0; vhigh = 0;
        slow = 0; mask = 0; kind = 0; addr = 0; wdata = 0; pc_value = 0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk); sys_rst = 0;
        repeat (40) @(negedge sys_clk);
        t_reset();
        t_clk();
        t_rw();
        t_slow();
        t_dma();
        irq(3, TRAP_VECTOR);
        irq(2, VEC_HIGH_VECTOR);
        irq(1, VEC_LOW_VECTOR);
        t_mask_ack();
        results();
    end
endmodule
`default_nettype wire
